// file: core/flash_pkg.sv
// Constants shared by the flash command device and its host controller
// Behaviour
// - Reset opcode right after reset-enable resets
// - Any other command cancels the reset-enable
// - Deep power-down ignores the reset sequence
// - Reset stops jobs, clears volatile state (the code refuses reset while a job runs)
// - Power-down needs select raised after bit eight
// - Enter power-down within the entry time
// - Powered down: only release opcode is recognised
// - Power-up always lands in normal operation
// - Release, then hold select high wake time
// - Release plus dummies repeats device ID byte
// - Release with ID needs longer wake time
// - Release opcode ignored while busy
// - Manufacturer/device ID alternates, start by address
// - Standard ID: manufacturer, type, capacity bytes
// - Table read: address, eight dummies, then data
// - Host keeps upper table address bits zero
// - Three 256-byte security pages at 10h/20h/30h
// - Page erase needs latch and whole bytes
// - Erase holds busy, then clears busy, latch
// - Lock bits permanently block erase and program (the code clears them on RESET)
// - Page program needs latch, select held low
// - Page read: address, eight dummies, MSB first
// - Page read increments address, wraps in page
// - Page read ignored while busy
package flash_pkg;
    // ==========================================================
    // Clock and link timing
    localparam int MCLK_MHZ = 25;
    localparam int SCK_HALF = 8; // MCLK cycles per serial clock half
    localparam int SLEEP_ENTRY_NS = 3000; // sleep_entry_time
    localparam int WAKE_NS = 3000; // wake_time
    localparam int WAKE_ID_NS = 5000; // wake_with_id_time
    localparam int ERASE_NS = 20480;
    localparam int PROG_NS = 4000;
    localparam int SLEEP_CYC = (SLEEP_ENTRY_NS * MCLK_MHZ + 999) / 1000;
    localparam int WAKE_CYC = (WAKE_NS * MCLK_MHZ + 999) / 1000;
    localparam int WAKE_ID_CYC = (WAKE_ID_NS * MCLK_MHZ + 999) / 1000;
    localparam int ERASE_CYC = (ERASE_NS * MCLK_MHZ + 999) / 1000; // at least 256
    localparam int PROG_CYC = (PROG_NS * MCLK_MHZ + 999) / 1000;
    // ==========================================================
    // Opcodes
    localparam logic [7:0] OP_RST_EN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    localparam logic [7:0] OP_SLEEP = 8'hb9; // deep_sleep_cmd
    localparam logic [7:0] OP_WAKE = 8'hab;
    localparam logic [7:0] OP_MFR_DEV = 8'h90;
    localparam logic [7:0] OP_IDENT = 8'h9f; // identity_read_cmd
    localparam logic [7:0] OP_SFDP = 8'h5a;
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;
    localparam logic [7:0] OP_SEC_PROG = 8'h42;
    localparam logic [7:0] OP_SEC_READ = 8'h48;
    localparam logic [7:0] OP_WR_EN = 8'h06;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    // ==========================================================
    // Identity bytes: values are arbitrary
    localparam logic [7:0] MFR_ID = 8'h5c;
    localparam logic [7:0] DEVICE_ID = 8'h3a;
    localparam logic [7:0] MEM_TYPE = 8'h71;
    localparam logic [7:0] CAPACITY = 8'h16;
    // ==========================================================
    // Frame layout in bytes
    localparam logic [9:0] HDR_ONE = 10'd1;
    localparam logic [9:0] HDR_ADDR = 10'd4;
    localparam logic [9:0] HDR_DUMMY = 10'd5;
    localparam logic [9:0] BYTE_MAX = 10'h3ff;
    localparam logic [7:0] SEC_PAGE1 = 8'h10;
    localparam logic [7:0] SEC_PAGE2 = 8'h20;
    localparam logic [7:0] SEC_PAGE3 = 8'h30;
    localparam logic [1:0] SEC_NONE = 2'd3;
    localparam logic [7:0] ERASED = 8'hff;
    // ==========================================================
    // Host register map
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_RXDATA = 8'h04;
    localparam logic [7:0] REG_GUARD = 8'h08;
    localparam int CTRL_LAST_BIT = 8;
    localparam logic [15:0] GUARD_RESET = 16'h0000;
endpackage

// file: core/spi_link_if.sv
// Serial link between the host controller and the flash device
`timescale 1ns/1ps
interface spi_link_if;
    logic sck;
    logic cs_n;
    logic serial_in_line;
    logic miso;
    logic miso_oe;
    logic miso_line;
    // Pulled-up data-out wire
    assign miso_line = miso_oe ? miso : 1'b1;
    modport host (output sck, output cs_n, output serial_in_line, input miso_line);
    modport flash (input sck, input cs_n, input serial_in_line, output miso, output miso_oe);
endinterface

// file: core/sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    // ==========================================================
    // First stage read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // sync2

// file: core/flash_cmd_device.sv
// Flash command interpreter: reset, power-down, ID reads, security pages
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module flash_cmd_device
    import flash_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESET,
    spi_link_if.flash link,
    input wire logic [2:0] LOCK_SET,
    output logic BUSY,
    output logic WRITE_ENABLE_LATCH,
    output logic ASLEEP,
    output logic [2:0] LOCK
);
    typedef enum {J_IDLE, J_ERASE, J_PROG, J_SLEEP_IN, J_WAKING} job_t;

    // ==========================================================
    // Decoding helpers
    function automatic logic [1:0] sec_idx(input logic [23:0] a);
        if (a[23:16] != 8'h00) begin
            return SEC_NONE;
        end
        return (a[15:8] == SEC_PAGE1) ? 2'd0 : (a[15:8] == SEC_PAGE2) ? 2'd1 :
               (a[15:8] == SEC_PAGE3) ? 2'd2 : SEC_NONE;
    endfunction

    function automatic logic [9:0] hdr_len(input logic [7:0] op);
        unique case (op)
            OP_RD_STATUS, OP_IDENT: return HDR_ONE;
            OP_WAKE, OP_MFR_DEV: return HDR_ADDR;
            OP_SFDP, OP_SEC_READ: return HDR_DUMMY;
            default: return 10'd0;
        endcase
    endfunction

    function automatic logic [7:0] ident_byte(input logic [7:0] n);
        return (n == 8'd0) ? MFR_ID : (n == 8'd1) ? MEM_TYPE :
               (n == 8'd2) ? CAPACITY : 8'h00;
    endfunction

    function automatic logic [7:0] sfdp_byte(input logic [7:0] a);
        unique case (a)
            8'h00: return 8'h53;
            8'h01: return 8'h46;
            8'h02: return 8'h44;
            8'h03: return 8'h50;
            default: return ERASED;
        endcase
    endfunction

    logic [2:0] pins;
    logic sck_d, cs_d;
    logic [2:0] bit_in, obit;
    logic [9:0] byte_cnt;
    logic [7:0] shreg, opcode, oidx;
    logic [23:0] addr;
    logic ign, reset_en, write_enable_latch, asleep, prog_ok;
    logic [2:0] lock;
    logic [1:0] job_sel;
    logic [19:0] timer;
    job_t job;
    logic [7:0] sec_mem [3][256];

    // ==========================================================
    // Pin sampling and edge detection
    sync2 #(.W(3)) u_sync (
        .clk(MCLK),
        .rst(RESET),
        .d({link.sck, link.cs_n, link.serial_in_line}),
        .q(pins)
    );
    wire sck_s = pins[2];
    wire cs_s = pins[1];
    wire din_s = pins[0];

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            sck_d <= 1'b0;
            cs_d <= 1'b1;
        end else begin
            sck_d <= sck_s;
            cs_d <= cs_s;
        end
    end

    wire sck_rise = sck_s & ~sck_d & ~cs_s;
    wire sck_fall = ~sck_s & sck_d & ~cs_s;
    wire cs_rise = cs_s & ~cs_d;
    wire [7:0] next_byte = {shreg[6:0], din_s};
    wire byte_done = sck_rise & (bit_in == 3'd7);
    wire op_done = byte_done & (byte_cnt == 10'd0);
    wire [23:0] addr_next = {addr[15:0], next_byte};
    wire busy = (job == J_ERASE) | (job == J_PROG);

    // Which opcodes may start now
    wire accept_op = asleep ? (next_byte == OP_WAKE) :
                     ((job == J_WAKING) | (job == J_SLEEP_IN)) ? 1'b0 :
                     busy ? (next_byte == OP_RD_STATUS) : 1'b1;
    wire [1:0] sel = sec_idx(addr);
    wire sel_ok = (sel != SEC_NONE) && !lock[sel];
    wire [9:0] hdr = hdr_len(opcode);
    wire out_phase = ~ign & (hdr != 10'd0) & (byte_cnt >= hdr);
    wire whole = ~ign & (bit_in == 3'd0) & (byte_cnt != 10'd0);
    wire [7:0] rd_ptr = addr[7:0] + oidx;
    wire [7:0] status = {lock, 3'b000, write_enable_latch, busy};
    wire [7:0] sec_byte = (sel == SEC_NONE) ? ERASED : sec_mem[sel][rd_ptr];
    wire [7:0] id_pair = (addr[0] ^ oidx[0]) ? DEVICE_ID : MFR_ID;
    wire [7:0] cur_byte = (opcode == OP_RD_STATUS) ? status :
                          (opcode == OP_WAKE) ? DEVICE_ID :
                          (opcode == OP_MFR_DEV) ? id_pair :
                          (opcode == OP_IDENT) ? ident_byte(oidx) :
                          (opcode == OP_SFDP) ? sfdp_byte(rd_ptr) : sec_byte;
    wire prog_write = byte_done & prog_ok & (byte_cnt >= HDR_ADDR);
    wire [7:0] prog_ptr = addr[7:0] + byte_cnt[7:0] - HDR_ADDR[7:0];

    // ==========================================================
    // Frame shifter: bit and byte counts, opcode, address, data out
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            bit_in <= 3'd0;
            byte_cnt <= 10'd0;
            shreg <= 8'h00;
            opcode <= 8'h00;
            addr <= 24'h000000;
            obit <= 3'd0;
            oidx <= 8'h00;
            link.miso <= 1'b1;
            link.miso_oe <= 1'b0;
        end else if (cs_s) begin
            bit_in <= 3'd0;
            byte_cnt <= 10'd0;
            obit <= 3'd0;
            oidx <= 8'h00;
            link.miso_oe <= 1'b0;
        end else begin
            link.miso_oe <= out_phase;
            if (sck_rise) begin
                shreg <= next_byte;
                bit_in <= bit_in + 3'd1;
            end
            if (byte_done && byte_cnt != BYTE_MAX) begin
                byte_cnt <= byte_cnt + 10'd1;
            end
            if (op_done) begin
                opcode <= next_byte;
            end
            if (byte_done && byte_cnt != 10'd0 && byte_cnt < HDR_ADDR) begin
                addr <= addr_next;
            end
            if (sck_fall && out_phase) begin
                link.miso <= cur_byte[~obit]; // MSB first
                obit <= obit + 3'd1;
                if (obit == 3'd7) begin
                    oidx <= oidx + 8'd1;
                end
            end
        end
    end

    // ==========================================================
    // Device state: latches, jobs, timers, power-down
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            ign <= 1'b1;
            reset_en <= 1'b0;
            write_enable_latch <= 1'b0;
            asleep <= 1'b0;
            prog_ok <= 1'b0;
            lock <= 3'b000;
            job_sel <= 2'd0;
            timer <= 20'd0;
            job <= J_IDLE;
        end else begin
            lock <= lock | LOCK_SET; // Cleared only by RESET
            if (op_done) begin
                ign <= ~accept_op;
                if (accept_op && next_byte != OP_RST) begin
                    reset_en <= 1'b0;
                end
            end
            if (byte_done && byte_cnt == 10'd3) begin
                prog_ok <= (opcode == OP_SEC_PROG) & ~ign & write_enable_latch &
                           (sec_idx(addr_next) != SEC_NONE) &&
                           !lock[sec_idx(addr_next)];
            end
            if (job != J_IDLE) begin
                if (timer == 20'd0) begin
                    job <= J_IDLE;
                    if (job == J_SLEEP_IN) begin
                        asleep <= 1'b1;
                    end
                    if (busy) begin
                        write_enable_latch <= 1'b0;
                    end
                end else begin
                    timer <= timer - 20'd1;
                end
            end
            if (cs_rise && whole) begin
                prog_ok <= 1'b0;
                unique case (opcode)
                    OP_RST_EN: begin
                        if (byte_cnt == HDR_ONE) begin
                            reset_en <= 1'b1;
                        end
                    end
                    OP_RST: begin
                        if (byte_cnt == HDR_ONE && reset_en) begin
                            reset_en <= 1'b0;
                            write_enable_latch <= 1'b0;
                            job <= J_IDLE;
                            timer <= 20'd0;
                        end
                    end
                    OP_SLEEP: begin
                        if (byte_cnt == HDR_ONE) begin
                            job <= J_SLEEP_IN;
                            timer <= 20'(SLEEP_CYC - 1);
                        end
                    end
                    OP_WAKE: begin
                        if (asleep) begin
                            asleep <= 1'b0;
                            job <= J_WAKING;
                            timer <= (byte_cnt == HDR_ONE) ? 20'(WAKE_CYC - 1) :
                                     20'(WAKE_ID_CYC - 1);
                        end
                    end
                    OP_WR_EN: begin
                        write_enable_latch <= 1'b1;
                    end
                    OP_SEC_ERASE: begin
                        if (byte_cnt == HDR_ADDR && write_enable_latch && sel_ok) begin
                            job <= J_ERASE;
                            job_sel <= sel;
                            timer <= 20'(ERASE_CYC - 1);
                        end
                    end
                    OP_SEC_PROG: begin
                        if (prog_ok && byte_cnt > HDR_ADDR) begin
                            job <= J_PROG;
                            timer <= 20'(PROG_CYC - 1);
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Security page storage: erase one byte per cycle, program by AND
    always_ff @(posedge MCLK) begin
        if (job == J_ERASE && job_sel != SEC_NONE) begin
            sec_mem[job_sel][timer[7:0]] <= ERASED;
        end else if (prog_write && sel != SEC_NONE) begin
            sec_mem[sel][prog_ptr] <= sec_mem[sel][prog_ptr] & next_byte;
        end
    end

    assign BUSY = busy;
    assign WRITE_ENABLE_LATCH = write_enable_latch;
    assign ASLEEP = asleep;
    assign LOCK = lock;
endmodule // flash_cmd_device

// file: core/flash_host.sv
// Host SPI controller: byte engine driven from classic Wishbone registers
`timescale 1ns/1ps
module flash_host
    import flash_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic WB_CYC,
    input wire logic WB_STB,
    input wire logic WB_WE,
    input wire logic [7:0] WB_ADR,
    input wire logic [3:0] WB_SEL,
    input wire logic [31:0] WB_DAT_W,
    output logic [31:0] WB_DAT_R,
    output logic WB_ACK,
    spi_link_if.host link
);
    typedef enum {H_IDLE, H_LOW, H_HIGH, H_TAIL, H_GUARD} hstate_t;

    hstate_t state;
    logic [3:0] div;
    logic [2:0] bitn;
    logic [7:0] tx, rx;
    logic last;
    logic [15:0] guard, gcnt;
    logic miso_s;

    // ==========================================================
    // Bus decode
    wire req = WB_CYC & WB_STB & ~WB_ACK;
    wire wr_ctrl = req & WB_WE & (WB_ADR == REG_CONTROL) & WB_SEL[0] & WB_SEL[1];
    wire wr_guard = req & WB_WE & (WB_ADR == REG_GUARD);
    wire start = wr_ctrl & (state == H_IDLE); // Refused while busy
    wire half_done = (div == 4'(SCK_HALF - 1));
    wire [31:0] rd_mux = (WB_ADR == REG_CONTROL) ? {30'd0, ~link.cs_n, state != H_IDLE} :
                         (WB_ADR == REG_RXDATA) ? {24'd0, rx} :
                         (WB_ADR == REG_GUARD) ? {16'd0, guard} : 32'd0;

    sync2 #(.W(1)) u_sync (
        .clk(MCLK),
        .rst(RESET),
        .d(link.miso_line),
        .q(miso_s)
    );

    // ==========================================================
    // Wishbone slave: one-cycle registered answer
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            WB_ACK <= 1'b0;
            WB_DAT_R <= 32'd0;
            guard <= GUARD_RESET;
        end else begin
            WB_ACK <= req;
            if (req) begin
                WB_DAT_R <= rd_mux;
            end
            if (wr_guard && WB_SEL[0]) begin
                guard[7:0] <= WB_DAT_W[7:0];
            end
            if (wr_guard && WB_SEL[1]) begin
                guard[15:8] <= WB_DAT_W[15:8];
            end
        end
    end

    // ==========================================================
    // Byte engine: mode 0, select held low across bytes until last
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            state <= H_IDLE;
            div <= 4'd0;
            bitn <= 3'd0;
            tx <= 8'h00;
            rx <= 8'h00;
            last <= 1'b0;
            gcnt <= 16'd0;
            link.sck <= 1'b0;
            link.cs_n <= 1'b1;
            link.serial_in_line <= 1'b0;
        end else begin
            div <= half_done ? 4'd0 : div + 4'd1;
            unique case (state)
                H_IDLE: begin
                    div <= 4'd0;
                    if (start) begin
                        tx <= WB_DAT_W[7:0]; // Bytes go out as given
                        last <= WB_DAT_W[CTRL_LAST_BIT];
                        link.cs_n <= 1'b0;
                        link.serial_in_line <= WB_DAT_W[7];
                        bitn <= 3'd0;
                        state <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (half_done) begin
                        link.sck <= 1'b1;
                        state <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (half_done) begin
                        rx <= {rx[6:0], miso_s};
                        link.sck <= 1'b0;
                        if (bitn == 3'd7) begin
                            state <= last ? H_TAIL : H_IDLE;
                        end else begin
                            bitn <= bitn + 3'd1;
                            tx <= {tx[6:0], 1'b0};
                            link.serial_in_line <= tx[6];
                            state <= H_LOW;
                        end
                    end
                end
                H_TAIL: begin
                    if (half_done) begin
                        link.cs_n <= 1'b1;
                        gcnt <= guard;
                        state <= H_GUARD;
                    end
                end
                H_GUARD: begin
                    if (half_done) begin
                        if (gcnt == 16'd0) begin
                            state <= H_IDLE; // Select held high
                        end else begin
                            gcnt <= gcnt - 16'd1;
                        end
                    end
                end
            endcase
        end
    end
endmodule // flash_host

// file: testbench/flash_link_checker.sv
// Checker for the serial link between host and flash device
`timescale 1ns/1ps
module flash_link_checker (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic BUSY,
    input wire logic WRITE_ENABLE_LATCH,
    input wire logic ASLEEP
);
    logic [7:0] cs_hi_cnt;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    // ==========================================================
    // Cycles since select last rose, saturating
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            cs_hi_cnt <= 8'h00;
        end else if (!cs_n) begin
            cs_hi_cnt <= 8'h00;
        end else if (cs_hi_cnt != 8'hff) begin
            cs_hi_cnt <= cs_hi_cnt + 8'h01;
        end
    end
    // ==========================================================
    // Link and device state relations
    sck_idle_a: assert property (cs_n |-> !sck)
        else $error("serial clock high while deselected");
    oe_start_a: assert property ($rose(miso_oe) |-> !cs_n)
        else $error("data out enabled outside a frame");
    oe_stop_a: assert property ($rose(cs_n) |-> ##[1:6] !miso_oe)
        else $error("data out still driven after select rose");
    miso_edge_a: assert property (miso_oe && $changed(miso) |-> !sck)
        else $error("data out changed while serial clock high");
    busy_start_a: assert property ($rose(BUSY) |-> cs_n && $past(cs_n))
        else $error("job started inside a frame");
    busy_end_a: assert property ($fell(BUSY) |-> ##[0:1] !WRITE_ENABLE_LATCH)
        else $error("write latch still set after job end");
    sleep_entry_a: assert property ($rose(ASLEEP) |->
        cs_n && cs_hi_cnt >= 8'h4b && cs_hi_cnt <= 8'h5a)
        else $error("power-down entry outside its time");
    wake_cs_a: assert property ($fell(ASLEEP) |-> cs_n && $past(cs_n))
        else $error("wake while select low");
endmodule // flash_link_checker

// file: testbench/tb_top.sv
// Testbench joining host and flash device, driven over Wishbone
`timescale 1ns/1ps
module tb_top;
    import flash_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat_w = 32'h0;
    logic [31:0] dat_r;
    logic [31:0] q;
    logic ack;
    logic [2:0] lock_set = 3'h0;
    logic busy, write_enable_latch, asleep;
    logic [2:0] lock;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    spi_link_if link_bus();
    flash_host flash_host_inst (.MCLK(mclk), .RESET(rst), .WB_CYC(cyc), .WB_STB(stb),
        .WB_WE(we), .WB_ADR(adr), .WB_SEL(4'hf), .WB_DAT_W(dat_w), .WB_DAT_R(dat_r),
        .WB_ACK(ack), .link(link_bus));
    flash_cmd_device flash_cmd_device_inst (.MCLK(mclk), .RESET(rst), .link(link_bus),
        .LOCK_SET(lock_set), .BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch),
        .ASLEEP(asleep), .LOCK(lock));
    flash_link_checker flash_link_checker_inst (.MCLK(mclk), .RESET(rst),
        .sck(link_bus.sck), .cs_n(link_bus.cs_n), .miso(link_bus.miso),
        .miso_oe(link_bus.miso_oe), .BUSY(busy),
        .WRITE_ENABLE_LATCH(write_enable_latch), .ASLEEP(asleep));
    // Clock and hang guard
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            end_of_test();
        end
    end
    // ==========================================================
    // Bus and link tasks
    task automatic end_of_test();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do @(posedge mclk); while (ack !== 1'b1);
        r = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic xb(input logic [7:0] b, input logic last, output logic [7:0] r);
        logic [31:0] s;
        wb(1'b1, REG_CONTROL, {23'h0, last, b}, s);
        s = 32'h1;
        for (int i = 0; i < 800 && s[0] !== 1'b0; i++) wb(1'b0, REG_CONTROL, 32'h0, s);
        if (s[0] !== 1'b0) errors++; // A stuck engine counts as a mismatch
        wb(1'b0, REG_RXDATA, 32'h0, s);
        r = s[7:0];
    endtask
    task automatic cmd(input logic [7:0] h[$]);
        logic [7:0] r;
        foreach (h[i]) xb(h[i], i == h.size() - 1, r);
    endtask
    task automatic frame(input logic [7:0] h[$], input logic [7:0] e[$]);
        logic [7:0] r;
        foreach (h[i]) xb(h[i], 1'b0, r);
        foreach (e[i]) begin
            xb(8'h00, i == e.size() - 1, r);
            check("rx byte", {24'h0, e[i]}, {24'h0, r});
        end
    endtask
    task automatic idle();
        for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge mclk);
        if (busy !== 1'b0) errors++; // A job that never ends counts as a mismatch
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        check("asleep", 32'h0, {31'h0, asleep});
        wb(1'b1, REG_GUARD, 32'h10, q);
        wb(1'b0, REG_GUARD, 32'h0, q);
        check("guard", 32'h10, q);
        wb(1'b0, 8'h0c, 32'h0, q);
        check("unmapped", 32'h0, q);
        frame('{OP_IDENT}, '{MFR_ID, MEM_TYPE, CAPACITY});
        frame('{OP_MFR_DEV, 8'h00, 8'h00, 8'h01}, '{DEVICE_ID, MFR_ID, DEVICE_ID});
        frame('{OP_MFR_DEV, 8'h00, 8'h00, 8'h00}, '{MFR_ID, DEVICE_ID});
        frame('{OP_WAKE, 8'h00, 8'h00, 8'h00}, '{DEVICE_ID, DEVICE_ID});
        frame('{OP_SFDP, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h53, 8'h46, 8'h44, 8'h50});
        $display("identity test done");
        cmd('{OP_WR_EN});
        cmd('{OP_RST_EN});
        cmd('{OP_RST});
        check("write latch", 32'h0, {31'h0, write_enable_latch});
        cmd('{OP_WR_EN});
        cmd('{OP_RST_EN});
        frame('{OP_RD_STATUS}, '{8'h02});
        cmd('{OP_RST});
        check("write latch", 32'h1, {31'h0, write_enable_latch});
        cmd('{OP_SLEEP});
        check("asleep", 32'h1, {31'h0, asleep});
        frame('{OP_RD_STATUS}, '{8'hff});
        cmd('{OP_RST_EN});
        cmd('{OP_RST});
        check("write latch", 32'h1, {31'h0, write_enable_latch});
        cmd('{OP_WAKE});
        check("asleep", 32'h0, {31'h0, asleep});
        cmd('{OP_SLEEP});
        frame('{OP_WAKE, 8'h00, 8'h00, 8'h00}, '{DEVICE_ID});
        check("asleep", 32'h0, {31'h0, asleep});
        cmd('{OP_RST_EN});
        cmd('{OP_RST});
        check("write latch", 32'h0, {31'h0, write_enable_latch});
        $display("power test done");
        lock_set <= 3'h4;
        @(posedge mclk);
        lock_set <= 3'h0;
        cmd('{OP_WR_EN});
        check("lock", 32'h4, {29'h0, lock});
        frame('{OP_RD_STATUS}, '{8'h82});
        cmd('{OP_SEC_ERASE, 8'h00, SEC_PAGE1, 8'h00});
        check("busy", 32'h1, {31'h0, busy});
        frame('{OP_WAKE, 8'h00, 8'h00, 8'h00}, '{8'hff});
        idle();
        check("write latch", 32'h0, {31'h0, write_enable_latch});
        cmd('{OP_WR_EN});
        cmd('{OP_SEC_PROG, 8'h00, SEC_PAGE1, 8'hfe, 8'ha5, 8'h5a, 8'h3c});
        idle();
        frame('{OP_SEC_READ, 8'h00, SEC_PAGE1, 8'hfe, 8'h00}, '{8'ha5, 8'h5a, 8'h3c});
        cmd('{OP_SEC_ERASE, 8'h00, SEC_PAGE2, 8'h00});
        check("busy", 32'h0, {31'h0, busy});
        cmd('{OP_WR_EN});
        cmd('{OP_SEC_ERASE, 8'h00, SEC_PAGE3, 8'h00});
        check("busy", 32'h0, {31'h0, busy});
        cmd('{OP_WR_EN});
        cmd('{OP_SEC_ERASE, 8'h00, SEC_PAGE2, 8'h00});
        frame('{OP_SEC_READ, 8'h00, SEC_PAGE1, 8'hfe, 8'h00}, '{8'hff});
        idle();
        $display("security test done");
        end_of_test();
    end
endmodule // tb_top
